/* File: rtl/cabt_pkg.sv */
// constants and helpers shared by both ends of the termination link
package cabt_pkg;
  // mode register addresses seen on the link
  localparam logic [7:0] CABT_MR_VALUE = 8'h0b;
  localparam logic [7:0] CABT_MR_OVR   = 8'h16;
  localparam logic [7:0] CABT_MR_PUCAL = 8'h03;
  // field positions inside the mode register operands
  localparam int CABT_VALUE_LSB = 4;
  localparam int CABT_CK_EN_BIT = 3;
  localparam int CABT_CS_EN_BIT = 4;
  localparam int CABT_CA_DIS_BIT = 5;
  localparam int CABT_PUCAL_BIT = 0;
  // value field codes
  localparam logic [2:0] CABT_VAL_OFF = 3'h0;
  localparam logic [2:0] CABT_VAL_240 = 3'h1;
  localparam logic [2:0] CABT_VAL_120 = 3'h2;
  localparam logic [2:0] CABT_VAL_80  = 3'h3;
  localparam logic [2:0] CABT_VAL_60  = 3'h4;
  localparam logic [2:0] CABT_VAL_48  = 3'h5;
  localparam logic [2:0] CABT_VAL_40  = 3'h6;
  // values after reset
  localparam logic [2:0] CABT_VALUE_RST = 3'h0;
  localparam logic       CABT_FLAG_RST  = 1'b0;
  // calibration point: 1 is vddq/2.5, 0 is vddq/3
  localparam logic       CABT_PUCAL_RST = 1'b0;
  // cycles one impedance calibration keeps the device busy
  localparam int CABT_ZQ_CYCLES = 16;
  // controller register byte offsets
  localparam logic [7:0] CABT_REG_VALUE  = 8'h00;
  localparam logic [7:0] CABT_REG_OVR    = 8'h04;
  localparam logic [7:0] CABT_REG_PUCAL  = 8'h08;
  localparam logic [7:0] CABT_REG_TRAIN  = 8'h0c;
  localparam logic [7:0] CABT_REG_STATUS = 8'h10;
  localparam logic [1:0] CABT_RESP_OKAY  = 2'h0;
  localparam logic [1:0] CABT_RESP_SLV   = 2'h2;

  // nominal resistance in ohms, zero when not a resistance code
  function automatic logic [7:0] cabt_ohms(input logic [2:0] code);
    unique case (code)
      CABT_VAL_240: cabt_ohms = 8'hf0;
      CABT_VAL_120: cabt_ohms = 8'h78;
      CABT_VAL_80:  cabt_ohms = 8'h50;
      CABT_VAL_60:  cabt_ohms = 8'h3c;
      CABT_VAL_48:  cabt_ohms = 8'h30;
      CABT_VAL_40:  cabt_ohms = 8'h28;
      default:      cabt_ohms = 8'h00;
    endcase
  endfunction

  // vddq/2.5 allows only the three highest resistances
  function automatic logic cabt_legal(input logic pucal,
                                      input logic [2:0] code);
    cabt_legal = !pucal || (code <= CABT_VAL_80);
  endfunction
endpackage

/* File: rtl/cabt_if.sv */
// link between controller and termination logic of the die
`timescale 1ns/100ps
interface cabt_if;
  logic       mrw_valid;  // one-cycle mode register write
  logic [7:0] mrw_addr;   // mode register address
  logic [7:0] mrw_op;     // mode register operand
  logic       zq_start;   // one-cycle calibration start
  logic       zq_busy;    // calibration in progress
  logic       cal_ok;     // calibration valid for current point

  modport dev (
    input  mrw_valid,
    input  mrw_addr,
    input  mrw_op,
    input  zq_start,
    output zq_busy,
    output cal_ok
  );

  modport ctl (
    output mrw_valid,
    output mrw_addr,
    output mrw_op,
    output zq_start,
    input  zq_busy,
    input  cal_ok
  );
endinterface

/* File: rtl/cabt_device.sv */
// die-side command/address termination decision logic
`timescale 1ns/100ps
// What this block does
// - value codes one to six select resistance
// - reset leaves all termination off
// - power states never drop termination
// - strap low never terminates address lines
// - strap high: clock, select; address unless disabled
// - strap low: clock, select by enables
// - power-down never changes the sensed strap
// - controller trains terminating rank first
// - vddq/2.5 allows only 240, 120, 80
// - value change needs no recalibration
// - new calibration point needs new calibration
module cabt_device #(
  parameter int ZQ_CYCLES = cabt_pkg::CABT_ZQ_CYCLES
) (
  input  wire logic       aclk,          // clock
  input  wire logic       aresetn,       // sync reset, low
  cabt_if.dev             link,          // controller link
  input  wire logic       strap_pad,     // bond pad, async
  input  wire logic       power_down,    // die in power-down
  input  wire logic       self_refresh,  // die in self-refresh
  output logic            term_ca_on,    // address lines on
  output logic            term_ck_on,    // clock pair on
  output logic            term_cs_on,    // chip select on
  output logic [7:0]      term_ohms,     // applied resistance
  output logic            strap_sensed   // sensed strap level
);
  import cabt_pkg::*;

  // ---------------------------------------------------------
  // state
  // ---------------------------------------------------------
  typedef struct packed {
    logic [2:0] sync;
    logic       strap;
    logic [2:0] value;
    logic       ck_en;
    logic       cs_en;
    logic       ca_dis;
    logic       pucal;
    logic       zq_busy;
    logic [7:0] zq_cnt;
    logic       cal_ok;
    logic       ca_on;
    logic       ck_on;
    logic       cs_on;
    logic [7:0] ohms;
  } cabt_dev_s;

  cabt_dev_s r;
  cabt_dev_s n;
  logic      enabled;

  localparam logic [7:0] ZQ_LAST = 8'(ZQ_CYCLES - 1);

  // ---------------------------------------------------------
  // next state
  // ---------------------------------------------------------
  always_comb begin
    n = r;
    // sync[0] feeds only sync[1]
    n.sync = {r.sync[1:0], strap_pad};
    // strap follows the pad only outside power states
    if (r.sync[1] == r.sync[2] && !power_down &&
        !self_refresh) begin
      n.strap = r.sync[2];
    end

    if (link.mrw_valid) begin
      unique case (link.mrw_addr)
        CABT_MR_VALUE: begin
          // value change keeps the calibration valid
          n.value = link.mrw_op[CABT_VALUE_LSB +: 3];
        end
        CABT_MR_OVR: begin
          n.ck_en  = link.mrw_op[CABT_CK_EN_BIT];
          n.cs_en  = link.mrw_op[CABT_CS_EN_BIT];
          n.ca_dis = link.mrw_op[CABT_CA_DIS_BIT];
        end
        CABT_MR_PUCAL: begin
          if (link.mrw_op[CABT_PUCAL_BIT] != r.pucal) begin
            n.cal_ok = 1'b0;
          end
          n.pucal = link.mrw_op[CABT_PUCAL_BIT];
        end
        default: begin
        end
      endcase
    end

    // a start while busy is ignored
    if (r.zq_busy) begin
      if (r.zq_cnt == ZQ_LAST) begin
        n.zq_busy = 1'b0;
        n.zq_cnt  = 8'h00;
        n.cal_ok  = 1'b1;
      end else begin
        n.zq_cnt = r.zq_cnt + 8'h01;
      end
    end else if (link.zq_start) begin
      n.zq_busy = 1'b1;
      n.zq_cnt  = 8'h00;
    end

    // codes zero and seven mean disabled
    enabled = (r.value >= CABT_VAL_240) &&
              (r.value <= CABT_VAL_40);
    // power states are deliberately not looked at here
    n.ca_on = enabled && r.strap && !r.ca_dis;
    n.ck_on = enabled && (r.strap || r.ck_en);
    n.cs_on = enabled && (r.strap || r.cs_en);
    n.ohms  = enabled ? cabt_ohms(r.value) : 8'h00;
  end

  // ---------------------------------------------------------
  // registers
  // ---------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r.sync    <= 3'h0;
      r.strap   <= 1'b0;
      r.value   <= CABT_VALUE_RST;
      r.ck_en   <= CABT_FLAG_RST;
      r.cs_en   <= CABT_FLAG_RST;
      r.ca_dis  <= CABT_FLAG_RST;
      r.pucal   <= CABT_PUCAL_RST;
      r.zq_busy <= 1'b0;
      r.zq_cnt  <= 8'h00;
      r.cal_ok  <= 1'b0;
      r.ca_on   <= 1'b0;
      r.ck_on   <= 1'b0;
      r.cs_on   <= 1'b0;
      r.ohms    <= 8'h00;
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------
  // outputs
  // ---------------------------------------------------------
  assign term_ca_on   = r.ca_on;
  assign term_ck_on   = r.ck_on;
  assign term_cs_on   = r.cs_on;
  assign term_ohms    = r.ohms;
  assign strap_sensed = r.strap;
  assign link.zq_busy = r.zq_busy;
  assign link.cal_ok  = r.cal_ok;
endmodule

/* File: rtl/cabt_ctrl.sv */
// controller end: axi4-lite registers driving the link
`timescale 1ns/100ps
module cabt_ctrl (
  input  wire logic        aclk,           // clock
  input  wire logic        aresetn,        // sync reset, low
  cabt_if.ctl              link,           // device link
  input  wire logic        term_rank,      // this rank terminates
  input  wire logic        term_trained,   // terminating rank done
  input  wire logic [7:0]  s_awaddr,       // write address
  input  wire logic        s_awvalid,      // write address valid
  output logic             s_awready,      // write address ready
  input  wire logic [31:0] s_wdata,        // write data
  input  wire logic [3:0]  s_wstrb,        // write strobes
  input  wire logic        s_wvalid,       // write data valid
  output logic             s_wready,       // write data ready
  output logic [1:0]       s_bresp,        // write response
  output logic             s_bvalid,       // write response valid
  input  wire logic        s_bready,       // write response ready
  input  wire logic [7:0]  s_araddr,       // read address
  input  wire logic        s_arvalid,      // read address valid
  output logic             s_arready,      // read address ready
  output logic [31:0]      s_rdata,        // read data
  output logic [1:0]       s_rresp,        // read response
  output logic             s_rvalid,       // read data valid
  input  wire logic        s_rready        // read data ready
);
  import cabt_pkg::*;

  // ---------------------------------------------------------
  // state
  // ---------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ZQ_GO,
    ST_ZQ_ARM,
    ST_ZQ_WAIT
  } cabt_st_e;

  typedef struct packed {
    cabt_st_e    st;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [2:0]  value;
    logic [2:0]  ovr;
    logic        pucal;
    logic        err;
    logic        trained;
    logic        mrw_valid;
    logic [7:0]  mrw_addr;
    logic [7:0]  mrw_op;
    logic        zq_start;
  } cabt_ctl_s;

  cabt_ctl_s   r;
  cabt_ctl_s   n;
  logic        do_wr;
  logic [31:0] status;

  assign s_awready = !r.aw_got && !r.bvalid;
  assign s_wready  = !r.w_got && !r.bvalid;
  assign s_arready = !r.rvalid;
  assign do_wr     = r.aw_got && r.w_got && !r.bvalid &&
                     (r.st == ST_IDLE);
  assign status    = {27'h0, link.zq_busy, r.trained, r.err,
                      link.cal_ok, (r.st != ST_IDLE)};

  // ---------------------------------------------------------
  // next state
  // ---------------------------------------------------------
  always_comb begin
    n = r;
    n.mrw_valid = 1'b0;
    n.zq_start  = 1'b0;
    if (s_awvalid && s_awready) begin
      n.aw_got  = 1'b1;
      n.aw_addr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      n.w_got  = 1'b1;
      n.w_data = s_wdata;
    end
    if (r.bvalid && s_bready) begin
      n.bvalid = 1'b0;
    end

    if (do_wr) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = CABT_RESP_OKAY;
      unique case (r.aw_addr)
        CABT_REG_VALUE: begin
          if (!cabt_legal(r.pucal, r.w_data[2:0])) begin
            n.err   = 1'b1;
            n.bresp = CABT_RESP_SLV;
          end else begin
            // new value goes out without recalibration
            n.value     = r.w_data[2:0];
            n.mrw_valid = 1'b1;
            n.mrw_addr  = CABT_MR_VALUE;
            n.mrw_op    = {1'b0, r.w_data[2:0], 4'h0};
          end
        end
        CABT_REG_OVR: begin
          n.ovr       = r.w_data[2:0];
          n.mrw_valid = 1'b1;
          n.mrw_addr  = CABT_MR_OVR;
          n.mrw_op    = {2'h0, r.w_data[2:0], 3'h0};
        end
        CABT_REG_PUCAL: begin
          if (!cabt_legal(r.w_data[0], r.value)) begin
            n.err   = 1'b1;
            n.bresp = CABT_RESP_SLV;
          end else begin
            n.pucal     = r.w_data[0];
            n.mrw_valid = 1'b1;
            n.mrw_addr  = CABT_MR_PUCAL;
            n.mrw_op    = {7'h0, r.w_data[0]};
            n.st        = ST_ZQ_GO;
          end
        end
        CABT_REG_TRAIN: begin
          if (term_rank || term_trained) begin
            n.trained = 1'b1;
          end else begin
            n.err   = 1'b1;
            n.bresp = CABT_RESP_SLV;
          end
        end
        CABT_REG_STATUS: begin
          if (r.w_data[2] && s_wstrb[0]) begin
            n.err = 1'b0;
          end
        end
        default: begin
          n.bresp = CABT_RESP_SLV;
        end
      endcase
    end

    unique case (r.st)
      ST_IDLE: begin
      end
      ST_ZQ_GO: begin
        n.zq_start = 1'b1;
        n.st       = ST_ZQ_ARM;
      end
      ST_ZQ_ARM: begin
        if (link.zq_busy) begin
          n.st = ST_ZQ_WAIT;
        end
      end
      ST_ZQ_WAIT: begin
        if (!link.zq_busy) begin
          n.st = ST_IDLE;
        end
      end
    endcase

    if (r.rvalid && s_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      n.rvalid = 1'b1;
      n.rresp  = CABT_RESP_OKAY;
      unique case (s_araddr)
        CABT_REG_VALUE:  n.rdata = {29'h0, r.value};
        CABT_REG_OVR:    n.rdata = {29'h0, r.ovr};
        CABT_REG_PUCAL:  n.rdata = {31'h0, r.pucal};
        CABT_REG_TRAIN:  n.rdata = {31'h0, r.trained};
        CABT_REG_STATUS: n.rdata = status;
        default: begin
          n.rdata = 32'h0;
          n.rresp = CABT_RESP_SLV;
        end
      endcase
    end
  end

  // ---------------------------------------------------------
  // registers
  // ---------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r       <= '0;
      r.st    <= ST_IDLE;
      r.value <= CABT_VALUE_RST;
      r.pucal <= CABT_PUCAL_RST;
    end else begin
      r <= n;
    end
  end

  assign s_bvalid       = r.bvalid;
  assign s_bresp        = r.bresp;
  assign s_rvalid       = r.rvalid;
  assign s_rresp        = r.rresp;
  assign s_rdata        = r.rdata;
  assign link.mrw_valid = r.mrw_valid;
  assign link.mrw_addr  = r.mrw_addr;
  assign link.mrw_op    = r.mrw_op;
  assign link.zq_start  = r.zq_start;
endmodule

/* File: tb/cabt_chk.sv */
// assertions on the termination link and the die outputs
`timescale 1ns/100ps
module cabt_chk
  import cabt_pkg::*;
#(
  parameter int ZQ_CYCLES = CABT_ZQ_CYCLES
) (
  input wire logic       aclk,         // clock
  input wire logic       aresetn,      // sync reset, low
  input wire logic       mrw_valid,    // mode register write
  input wire logic [7:0] mrw_addr,     // register address
  input wire logic [7:0] mrw_op,       // operand
  input wire logic       zq_start,     // calibration start
  input wire logic       zq_busy,      // calibration busy
  input wire logic       cal_ok,       // calibration valid
  input wire logic       power_down,   // power-down state
  input wire logic       self_refresh, // self-refresh state
  input wire logic       strap_sensed, // sensed strap
  input wire logic       term_ca_on,   // address lines on
  input wire logic       term_ck_on,   // clock pair on
  input wire logic       term_cs_on,   // chip select on
  input wire logic [7:0] term_ohms     // resistance
);
  // ----------------------------------------
  // shadow of the die registers
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] code;
    logic       ck;
    logic       cs;
    logic       dis;
    logic       pucal;
    logic [4:0] cnt;
  } cabt_chk_s;
  cabt_chk_s  st_r;
  cabt_chk_s  st_nxt;
  logic       en;
  logic [7:0] ohm;
  assign en = (st_r.code != 3'h0) && (st_r.code != 3'h7);
  always_comb begin
    st_nxt = st_r;
    st_nxt.cnt = zq_busy ? st_r.cnt + 5'h1 : 5'h0;
    if (mrw_valid && mrw_addr == CABT_MR_VALUE) st_nxt.code = mrw_op[6:4];
    if (mrw_valid && mrw_addr == CABT_MR_OVR) begin
      st_nxt.ck = mrw_op[3];
      st_nxt.cs = mrw_op[4];
      st_nxt.dis = mrw_op[5];
    end
    if (mrw_valid && mrw_addr == CABT_MR_PUCAL) st_nxt.pucal = mrw_op[0];
    case (st_r.code)
      3'h1:    ohm = 8'hf0;
      3'h2:    ohm = 8'h78;
      3'h3:    ohm = 8'h50;
      3'h4:    ohm = 8'h3c;
      3'h5:    ohm = 8'h30;
      3'h6:    ohm = 8'h28;
      default: ohm = 8'h00;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) st_r <= '0;
    else st_r <= st_nxt;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence pucal_mrw;
    mrw_valid && mrw_addr == CABT_MR_PUCAL;
  endsequence
  sequence zq_kick;
    zq_start ##1 zq_busy;
  endsequence
  ca_term_a: assert property (
    term_ca_on == $past(en && strap_sensed && !st_r.dis))
    else $error("address termination wrong");
  ck_term_a: assert property (
    term_ck_on == $past(en && (strap_sensed || st_r.ck)))
    else $error("clock termination wrong");
  cs_term_a: assert property (
    term_cs_on == $past(en && (strap_sensed || st_r.cs)))
    else $error("select termination wrong");
  ohm_value_a: assert property (
    (term_ca_on || term_ck_on || term_cs_on) |-> term_ohms == $past(ohm))
    else $error("resistance wrong");
  strap_hold_a: assert property (
    (power_down || self_refresh) [*3] |-> $stable(strap_sensed))
    else $error("strap changed in power state");
  zq_length_a: assert property (
    $fell(zq_busy) |-> int'(st_r.cnt) == ZQ_CYCLES)
    else $error("calibration length wrong");
  cal_done_a: assert property (
    $fell(zq_busy) |-> ##[0:1] cal_ok)
    else $error("calibration not marked valid");
  cal_clear_a: assert property (
    pucal_mrw and (mrw_op[0] != st_r.pucal) |=> !cal_ok)
    else $error("calibration kept after point change");
  zq_order_a: assert property (
    pucal_mrw |=> zq_kick)
    else $error("no calibration after point change");
  legal_value_a: assert property (
    mrw_valid && mrw_addr == CABT_MR_VALUE && st_r.pucal |->
      mrw_op[6:4] <= CABT_VAL_80)
    else $error("illegal value sent");
  legal_point_a: assert property (
    pucal_mrw and mrw_op[0] |-> st_r.code <= CABT_VAL_80)
    else $error("illegal point sent");
endmodule

/* File: tb/tb_top.sv */
// testbench joining controller and die over the link
`timescale 1ns/100ps
module tb_top;
  import cabt_pkg::*;
  typedef struct packed {
    logic       s;
    logic [2:0] code;
    logic [2:0] ovr;
    logic [2:0] exp;
    logic [7:0] ohm;
  } cabt_row_s;
  logic aclk, aresetn, strap_pad, power_down, self_refresh;
  logic term_rank, term_trained, term_ca_on, term_ck_on, term_cs_on;
  logic strap_sensed, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
  logic s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [7:0] term_ohms, s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rsp;
  int err_total, checks;
  // ohm ff: resistance not compared
  cabt_row_s rows [12] = '{
    '{1'b1, 3'h1, 3'h0, 3'h7, 8'hf0}, '{1'b1, 3'h2, 3'h4, 3'h3, 8'h78},
    '{1'b1, 3'h3, 3'h0, 3'h7, 8'h50}, '{1'b1, 3'h4, 3'h3, 3'h7, 8'h3c},
    '{1'b1, 3'h5, 3'h0, 3'h7, 8'h30}, '{1'b1, 3'h6, 3'h0, 3'h7, 8'h28},
    '{1'b1, 3'h7, 3'h0, 3'h0, 8'h00}, '{1'b1, 3'h0, 3'h0, 3'h0, 8'h00},
    '{1'b0, 3'h2, 3'h0, 3'h0, 8'h78}, '{1'b0, 3'h2, 3'h1, 3'h2, 8'h78},
    '{1'b0, 3'h2, 3'h2, 3'h1, 8'h78}, '{1'b0, 3'h2, 3'h7, 3'h3, 8'h78}};
  cabt_if link();
  cabt_device #(.ZQ_CYCLES(4)) cabt_device_inst (.aclk, .aresetn, .link,
    .strap_pad, .power_down, .self_refresh, .term_ca_on, .term_ck_on,
    .term_cs_on, .term_ohms, .strap_sensed);
  cabt_ctrl cabt_ctrl_inst (.aclk, .aresetn, .link, .term_rank,
    .term_trained, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
  cabt_chk #(.ZQ_CYCLES(4)) cabt_chk_inst (.aclk, .aresetn,
    .mrw_valid(link.mrw_valid), .mrw_addr(link.mrw_addr),
    .mrw_op(link.mrw_op), .zq_start(link.zq_start),
    .zq_busy(link.zq_busy), .cal_ok(link.cal_ok), .power_down,
    .self_refresh, .strap_sensed, .term_ca_on, .term_ck_on, .term_cs_on,
    .term_ohms);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge aclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = s_awvalid && s_awready;
      w = s_wvalid && s_wready;
      b = s_bvalid;
      rsp = s_bresp;
      @(posedge aclk);
      if (aw) s_awvalid <= 1'b0;
      if (w) s_wvalid <= 1'b0;
    end
    s_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar, r;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge aclk);
      ar = s_arvalid && s_arready;
      r = s_rvalid;
      rd = s_rdata;
      rsp = s_rresp;
      @(posedge aclk);
      if (ar) s_arvalid <= 1'b0;
    end
    s_rready <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    #200000;
    err_total++;
    finish_test;
  end
  initial begin
    {aresetn, strap_pad, power_down, self_refresh, term_rank} = '0;
    {term_trained, s_awvalid, s_wvalid, s_bready, s_arvalid} = '0;
    {s_rready, s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    settle(6);
    chk({term_ca_on, term_ck_on, term_cs_on, link.cal_ok}, 0);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      @(posedge aclk) strap_pad <= rows[i].s;
      axi_wr(CABT_REG_VALUE, {29'h0, rows[i].code});
      chk(rsp, CABT_RESP_OKAY);
      axi_wr(CABT_REG_OVR, {29'h0, rows[i].ovr});
      settle(6);
      chk({term_ca_on, term_ck_on, term_cs_on},
          rows[i].exp);
      if (rows[i].ohm != 8'hff) begin
        chk(term_ohms, rows[i].ohm);
      end
    end
    $display("table test done");
    @(posedge aclk) strap_pad <= 1'b1;
    axi_wr(CABT_REG_OVR, 0);
    @(posedge aclk) power_down <= 1'b1;
    @(posedge aclk) strap_pad <= 1'b0;
    settle(8);
    chk({strap_sensed, term_ca_on, term_ck_on}, 3'h7);
    @(posedge aclk) {power_down, self_refresh} <= 2'b01;
    settle(8);
    chk({strap_sensed, term_ca_on, term_cs_on}, 3'h7);
    @(posedge aclk) self_refresh <= 1'b0;
    settle(8);
    chk({strap_sensed, term_ca_on}, 2'h0);
    $display("power test done");
    @(posedge aclk) strap_pad <= 1'b1;
    axi_wr(CABT_REG_VALUE, 6);
    axi_wr(CABT_REG_PUCAL, 1);
    chk(rsp, CABT_RESP_SLV);
    axi_rd(CABT_REG_STATUS);
    chk(rd[2], 1'b1);
    axi_wr(CABT_REG_STATUS, 32'h4);
    axi_rd(CABT_REG_STATUS);
    chk(rd[2], 1'b0);
    axi_wr(CABT_REG_VALUE, 3);
    axi_wr(CABT_REG_PUCAL, 1);
    chk(rsp, CABT_RESP_OKAY);
    // start pulse, one edge to busy, then four busy cycles
    settle(8);
    chk(link.cal_ok, 1'b1);
    for (int c = 1; c < 7; c++) begin
      axi_wr(CABT_REG_VALUE, c);
      chk(rsp, (c < 4) ? CABT_RESP_OKAY : CABT_RESP_SLV);
    end
    settle(4);
    chk(term_ohms, 8'h50);
    axi_wr(CABT_REG_VALUE, 1);
    settle(4);
    chk({link.cal_ok, term_ohms}, 9'h1f0);
    axi_rd(CABT_REG_VALUE);
    chk(rd, 1);
    axi_wr(CABT_REG_PUCAL, 0);
    settle(2);
    chk(link.cal_ok, 1'b0);
    settle(6);
    chk(link.cal_ok, 1'b1);
    $display("calibration test done");
    axi_rd(8'h20);
    chk(rsp, CABT_RESP_SLV);
    chk(rd, 32'h0);
    axi_wr(8'h14, 0);
    chk(rsp, CABT_RESP_SLV);
    axi_wr(CABT_REG_TRAIN, 1);
    chk(rsp, CABT_RESP_SLV);
    @(posedge aclk) term_rank <= 1'b1;
    axi_wr(CABT_REG_TRAIN, 1);
    chk(rsp, CABT_RESP_OKAY);
    axi_rd(CABT_REG_TRAIN);
    chk(rd[0], 1'b1);
    $display("register test done");
    @(posedge aclk) aresetn <= 1'b0;
    settle(2);
    chk({term_ca_on, term_ck_on, term_cs_on, link.cal_ok}, 0);
    @(posedge aclk) aresetn <= 1'b1;
    settle(3);
    chk({term_ca_on, term_ck_on, term_cs_on, term_ohms}, 0);
    $display("second reset test done");
    finish_test;
  end
endmodule
